// file: common/frontend_defines.svh
// constants for the instruction fetch front end and its partner
// Overview of operation
// - reset loads boot location as next pc
// - fixed next-pc priority, debug highest, reset lowest
// - register jump uses valid target-buffer entry
// - conditional branch uses valid history-table prediction
// - return predicted from stack only once consumed
// - target-buffer and history-table predictions are flagged toward decode
// - reduced configuration disables every prediction
// - default next pc is word-aligned pc plus four
// - execute mispredict redirects fetch to correct target
// - full queue requests replay at given address
// - exception return jumps to presented saved pc
// - trap jumps to presented trap vector base
// - flush resumes at commit pc, clears queue, informs cache
// - debug overrides all redirects, fixed address, optional
// - request/response handshake to cache, word blocks
// - blocks realigned and queued; flush drops outstanding
// - up to two instructions extracted, one delivered per cycle
// - fetch exceptions travel with the fetched entry
// - entries offered to decode with valid and ready
// - controller flush clears fetch and pc state
// - queue holds four, full triggers replay
// - realigner state cleared on any redirect
`ifndef FRONTEND_DEFINES_SVH
`define FRONTEND_DEFINES_SVH
`define FE_QUEUE_DEPTH  3'h4
`define FE_PC_RESET     32'h0000_0000
`define FE_WORD_STEP    32'h0000_0004
`define FE_HALF_STEP    32'h0000_0002
`define FE_DEBUG_ADDR   32'h0000_0800
`define FE_OP_JALR      7'h67
`define FE_OP_BRANCH    7'h63
`define FE_REG_LINK     5'h01
`define FE_REG_ZERO     5'h00
`endif

// file: common/frontend_pkg.sv
// types shared by the fetch front end, its partner and their interface
package frontend_pkg;
  typedef logic [31:0] addr_type;
  typedef struct packed {
    logic [31:0] instr;
    addr_type    addr;
    logic        ex;
    logic        pred;
    logic        ret;
  } fetch_entry_type;
  typedef enum logic [2:0] {
    FS_BOOT = 3'b001,
    FS_IDLE = 3'b010,
    FS_WAIT = 3'b100
  } fetch_state_type;
endpackage

// file: common/frontend_if.sv
// link between the fetch front end and the cache/decode partner
`timescale 1ns/1ns
interface frontend_if;
  import frontend_pkg::*;
  logic            fetch_req;
  addr_type        fetch_addr;
  logic            fetch_kill;
  logic            fetch_gnt;
  logic            rsp_valid;
  addr_type        rsp_addr;
  logic [31:0]     rsp_data;
  logic            rsp_ex;
  logic            entry_valid;
  logic            entry_ready;
  fetch_entry_type entry;
  modport frontend (output fetch_req, fetch_addr, fetch_kill, entry_valid, entry,
                    input fetch_gnt, rsp_valid, rsp_addr, rsp_data, rsp_ex, entry_ready);
  modport partner  (input fetch_req, fetch_addr, fetch_kill, entry_valid, entry,
                    output fetch_gnt, rsp_valid, rsp_addr, rsp_data, rsp_ex, entry_ready);
endinterface

// file: design/fetch_frontend.sv
// pc generation and fetch stage: realigner, predecode, four-entry queue
`timescale 1ns/1ns
`include "frontend_defines.svh"
module fetch_frontend
(
  // clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 nrst_in,
  // link to cache and decode
  frontend_if.frontend              link,
  // configuration
  input  wire logic                 reduced_cfg_in,
  input  wire frontend_pkg::addr_type boot_addr_in,
  // redirect sources
  input  wire logic                 mispredict_in,
  input  wire frontend_pkg::addr_type mispredict_pc_in,
  input  wire logic                 eret_in,
  input  wire frontend_pkg::addr_type epc_in,
  input  wire logic                 trap_event_in,
  input  wire frontend_pkg::addr_type trap_base_in,
  input  wire logic                 flush_in,
  input  wire logic                 flush_redirect_select_in,
  input  wire frontend_pkg::addr_type flush_resume_pc_in,
  input  wire logic                 debug_redirect_event_in,
  input  wire logic                 predictor_clear_request_in,
  // predictor lookups
  output frontend_pkg::addr_type    lookup_pc_out,
  output logic                      predictor_clear_out,
  input  wire logic                 btb_valid_in,
  input  wire frontend_pkg::addr_type btb_target_in,
  input  wire logic                 bht_valid_in,
  input  wire logic                 bht_taken_in,
  input  wire frontend_pkg::addr_type bht_target_in,
  input  wire logic                 ras_valid_in,
  input  wire frontend_pkg::addr_type ras_target_in
);
  import frontend_pkg::*;

  // predecode: {return, register jump, conditional branch}
  function automatic logic [2:0] scan_cf(input logic [31:0] i);
    logic cmp;
    logic jr;
    logic br;
    logic jl;
    cmp = (i[1:0] != 2'b11);
    br  = cmp ? (i[1:0] == 2'b01 && i[15:14] == 2'b11) : (i[6:0] == `FE_OP_BRANCH);
    jr  = (i[1:0] == 2'b10) && (i[15:13] == 3'b100) && (i[6:2] == 5'h00)
          && (i[11:7] != `FE_REG_ZERO);
    jl  = cmp ? jr : (i[6:0] == `FE_OP_JALR);
    scan_cf = {jl && (cmp ? (i[11:7] == `FE_REG_LINK && !i[12])
                          : (i[19:15] == `FE_REG_LINK && i[11:7] == `FE_REG_ZERO)),
               jl, br};
  endfunction

  fetch_state_type state;
  addr_type        pc;
  logic            rsp_start;
  logic            drop;
  logic            flush_pending;
  logic            have_half;
  logic [15:0]     saved_half;
  addr_type        saved_addr;
  logic [2:0]      count;
  logic [1:0]      wptr;
  logic [1:0]      rptr;
  fetch_entry_type q [0:3];
  logic            predictor_clear;

  // redirect decode; the debug jump does not exist in the reduced build
  wire debug_eff    = debug_redirect_event_in && !reduced_cfg_in;
  wire flush_sel    = flush_in && flush_redirect_select_in;
  wire redirect_ext = mispredict_in || eret_in || trap_event_in || flush_in || debug_eff;
  wire pop          = link.entry_valid && link.entry_ready;
  wire ras_take     = pop && link.entry.ret && ras_valid_in && !reduced_cfg_in;
  wire kill_path    = redirect_ext || ras_take;

  // request only from a settled pc; redirects land first, then fetch
  wire req     = (state == FS_IDLE) && !kill_path;
  wire grant   = req && link.fetch_gnt;
  wire accept  = (state == FS_WAIT) && link.rsp_valid && !drop && !kill_path;
  assign link.fetch_req  = req;
  assign link.fetch_addr = {pc[31:2], 2'b00};
  assign link.fetch_kill = flush_pending;

  // realigner: split one 32-bit block into up to two instructions
  wire [15:0] h0    = link.rsp_data[15:0];
  wire [15:0] h1    = link.rsp_data[31:16];
  wire        c0    = (h0[1:0] != 2'b11);
  wire        c1    = (h1[1:0] != 2'b11);
  wire        ex    = link.rsp_ex;
  wire        start = rsp_start && !have_half;
  wire        s1    = have_half || (!start && c0);
  wire        v0    = accept;
  wire        v1    = accept && !ex && s1 && c1;
  wire        save  = accept && !ex && (s1 || start) && !c1;
  wire        v0_ok = ex || have_half || !start || c1;
  wire [31:0] i0    = ex ? link.rsp_data : have_half ? {h0, saved_half}
                    : start ? {16'h0000, h1} : c0 ? {16'h0000, h0} : link.rsp_data;
  wire [31:0] i1    = {16'h0000, h1};
  addr_type   a0;
  addr_type   a1;
  assign a1 = link.rsp_addr + `FE_HALF_STEP;
  assign a0 = have_half ? saved_addr : start ? a1 : link.rsp_addr;

  // prediction on the first predicted-taken control-flow instruction of the block
  wire [2:0] cf0 = scan_cf(i0);
  wire [2:0] cf1 = scan_cf(i1);
  wire take0 = !reduced_cfg_in && !ex && ((cf0[1] && !cf0[2] && btb_valid_in)
               || (cf0[0] && bht_valid_in && bht_taken_in));
  wire take1 = !reduced_cfg_in && ((cf1[1] && !cf1[2] && btb_valid_in)
               || (cf1[0] && bht_valid_in && bht_taken_in));
  wire v0p   = v0 && v0_ok;
  wire pred0 = v0p && take0;
  wire v1p   = v1 && !pred0;
  wire pred1 = v1p && take1;
  addr_type pred_target;
  assign pred_target = ((pred0 ? cf0[1] : cf1[1]) && !(pred0 ? cf0[2] : cf1[2]))
                       ? btb_target_in : bht_target_in;
  assign lookup_pc_out = link.rsp_addr;
  assign predictor_clear_out = predictor_clear;

  // queue admission; what does not fit is fetched again
  wire fit0    = v0p && (count < `FE_QUEUE_DEPTH);
  wire fit1    = v1p && (v0p ? (count < `FE_QUEUE_DEPTH - 3'h1) : (count < `FE_QUEUE_DEPTH));
  wire replay  = (v0p && !fit0) || (v1p && !fit1);
  wire pred_ok = (pred0 && fit0) || (pred1 && fit1);
  addr_type replay_addr;
  assign replay_addr = (v0p && !fit0) ? a0 : a1;
  wire [1:0] wptr1  = wptr + {1'b0, fit0};
  wire [2:0] push_n = {2'b00, fit0} + {2'b00, fit1};
  wire realign_clr  = kill_path || replay || pred_ok;

  // next pc, lowest priority first
  addr_type n_boot;
  addr_type n_pred;
  addr_type n_seq;
  addr_type n_mis;
  addr_type n_rep;
  addr_type n_eret;
  addr_type n_trap;
  addr_type n_flush;
  addr_type next_pc;
  assign n_boot  = (state == FS_BOOT) ? boot_addr_in : pc;
  assign n_pred  = ras_take ? ras_target_in : pred_ok ? pred_target : n_boot;
  assign n_seq   = grant ? ({pc[31:2], 2'b00} + `FE_WORD_STEP) : n_pred;
  assign n_mis   = mispredict_in ? mispredict_pc_in : n_seq;
  assign n_rep   = replay ? replay_addr : n_mis;
  assign n_eret  = eret_in ? epc_in : n_rep;
  assign n_trap  = trap_event_in ? trap_base_in : n_eret;
  assign n_flush = flush_sel ? flush_resume_pc_in : n_trap;
  assign next_pc = debug_eff ? `FE_DEBUG_ADDR : n_flush;

  // decode side of the queue; head entry is held until taken
  assign link.entry_valid = (count != 3'h0);
  assign link.entry       = q[rptr];

  // pc, fetch state and flush forwarding
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state           <= FS_BOOT;
      pc              <= `FE_PC_RESET;
      rsp_start       <= 1'b0;
      drop            <= 1'b0;
      flush_pending   <= 1'b0;
      predictor_clear <= 1'b0;
    end
    else
    begin
      pc              <= next_pc;
      predictor_clear <= predictor_clear_request_in;
      flush_pending   <= flush_in || (flush_pending && !grant);
      if (grant)
        rsp_start <= pc[1];
      case (state)
        FS_BOOT: state <= FS_IDLE;
        FS_IDLE: if (grant) state <= FS_WAIT;
        FS_WAIT:
        begin
          // a redirect while waiting marks the answer as stale
          if (link.rsp_valid)
          begin
            state <= FS_IDLE;
            drop  <= 1'b0;
          end
          else if (kill_path)
            drop <= 1'b1;
        end
        default: state <= FS_IDLE;
      endcase
    end
  end

  // realigner partial-instruction state
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      have_half  <= 1'b0;
      saved_half <= 16'h0000;
      saved_addr <= `FE_PC_RESET;
    end
    else if (realign_clr)
      have_half <= 1'b0;
    else if (accept)
    begin
      have_half  <= save;
      saved_half <= h1;
      saved_addr <= a1;
    end
  end

  // queue pointers; any redirect empties it, old-path entries must not reach decode
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      count <= 3'h0;
      wptr  <= 2'h0;
      rptr  <= 2'h0;
    end
    else if (kill_path)
    begin
      count <= 3'h0;
      wptr  <= 2'h0;
      rptr  <= 2'h0;
    end
    else
    begin
      count <= count + push_n - {2'b00, pop};
      wptr  <= wptr + push_n[1:0];
      rptr  <= rptr + {1'b0, pop};
    end
  end

  // queue storage, one writer per entry
  genvar e;
  generate
    for (e = 0; e < 4; e = e + 1)
    begin : g_entry
      wire wr0 = fit0 && !kill_path && (wptr == 2'(e));
      wire wr1 = fit1 && !kill_path && (wptr1 == 2'(e));
      always_ff @(posedge core_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
          q[e] <= '0;
        else if (wr0)
          q[e] <= '{instr: i0, addr: a0, ex: ex, pred: pred0, ret: cf0[2]};
        else if (wr1)
          q[e] <= '{instr: i1, addr: a1, ex: 1'b0, pred: pred1, ret: cf1[2]};
      end
    end
  endgenerate
endmodule

// file: design/fetch_partner.sv
// cache end and decode end facing the fetch front end
`timescale 1ns/1ns
`include "frontend_defines.svh"
module fetch_partner
(
  // clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    nrst_in,
  // link to the front end
  frontend_if.partner                  link,
  // instruction memory
  output logic                         mem_rd_out,
  output frontend_pkg::addr_type       mem_addr_out,
  input  wire logic [31:0]             mem_data_in,
  input  wire logic                    mem_err_in,
  output logic                         cache_flush_out,
  // decode user side
  output logic                         decode_valid_out,
  output frontend_pkg::fetch_entry_type decode_entry_out,
  input  wire logic                    decode_ready_in
);
  import frontend_pkg::*;

  logic busy;
  logic rsp_valid;
  addr_type rsp_addr;
  logic [31:0] rsp_data;
  logic rsp_ex;

  // one block in flight; grant only while idle so no request is lost
  wire grant = link.fetch_req && !busy;
  assign link.fetch_gnt = !busy;
  assign link.rsp_valid = rsp_valid;
  assign link.rsp_addr  = rsp_addr;
  assign link.rsp_data  = rsp_data;
  assign link.rsp_ex    = rsp_ex;

  // cache end: grant, memory read, answer
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      busy            <= 1'b0;
      mem_rd_out      <= 1'b0;
      mem_addr_out    <= `FE_PC_RESET;
      cache_flush_out <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_addr        <= `FE_PC_RESET;
      rsp_data        <= 32'h0000_0000;
      rsp_ex          <= 1'b0;
    end
    else
    begin
      mem_rd_out      <= grant;
      cache_flush_out <= grant && link.fetch_kill;
      rsp_valid       <= mem_rd_out;
      if (grant)
      begin
        busy         <= 1'b1;
        mem_addr_out <= {link.fetch_addr[31:2], 2'b00};
      end
      else if (rsp_valid)
        busy <= 1'b0;
      if (mem_rd_out)
      begin
        rsp_addr <= mem_addr_out;
        rsp_data <= mem_data_in;
        rsp_ex   <= mem_err_in;
      end
    end
  end

  // decode end: one holding stage, refilled in the cycle it drains
  assign link.entry_ready = !decode_valid_out || decode_ready_in;
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      decode_valid_out <= 1'b0;
      decode_entry_out <= '0;
    end
    else if (link.entry_ready)
    begin
      decode_valid_out <= link.entry_valid;
      decode_entry_out <= link.entry;
    end
  end
endmodule

// file: test/fetch_link_monitor.sv
// checker on the fetch and decode link between the two ends
`timescale 1ns/1ns
module fetch_link_monitor
(
  // clock and reset
  input wire logic                          core_clk_in,
  input wire logic                          nrst_in,
  // fetch request side
  input wire logic                          fetch_req,
  input wire frontend_pkg::addr_type        fetch_addr,
  input wire logic                          fetch_kill,
  input wire logic                          fetch_gnt,
  // response and decode side
  input wire logic                          rsp_valid,
  input wire frontend_pkg::addr_type        rsp_addr,
  input wire logic                          rsp_ex,
  input wire logic                          entry_valid,
  input wire logic                          entry_ready,
  input wire frontend_pkg::fetch_entry_type entry
);
  import frontend_pkg::*;
  wire logic granted;
  // a request counts only on the edge where it is granted
  assign granted = fetch_req && fetch_gnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // request side
  chk_addr_word: assert property (fetch_req |-> fetch_addr[1:0] == 2'h0)
    else $error("fetch address not word aligned");
  chk_one_outstanding: assert property (granted |=> !granted [*2])
    else $error("second grant while a block is outstanding");
  chk_kill_sent: assert property (fetch_kill |-> ##[0:8] granted)
    else $error("flush not forwarded with a request");
  chk_kill_ends: assert property ($fell(fetch_kill) |-> $past(granted))
    else $error("flush indication dropped without a granted request");
  // response side
  chk_rsp_latency: assert property (granted |-> ##2 rsp_valid)
    else $error("granted request got no block two cycles later");
  chk_rsp_cause: assert property (rsp_valid |-> $past(granted, 2))
    else $error("block delivered without a granted request");
  chk_rsp_block: assert property (rsp_valid |-> rsp_addr == $past(fetch_addr, 2))
    else $error("block address differs from requested one");
  chk_rsp_single: assert property (rsp_valid |=> !rsp_valid)
    else $error("block response longer than one cycle");
  // decode side: a refused entry may only vanish through a queue clear
  chk_entry_hold: assert property (entry_valid && !entry_ready |=> !entry_valid || $stable(entry))
    else $error("entry changed while decode refused it");
  cov_killed_req: cover property (granted && fetch_kill);
  cov_stalled: cover property (entry_valid && !entry_ready);
  cov_fault: cover property (rsp_valid && rsp_ex);
endmodule

// file: test/instruction_fetch_frontend_test.sv
// directed bench for the fetch front end joined to its cache and decode partner
`timescale 1ns/1ns
`include "frontend_defines.svh"
module instruction_fetch_frontend_test;
  import frontend_pkg::*;
  localparam addr_type BOOT = 32'h0000_1000;
  localparam logic [31:0] JALR = 32'h0003_0067;
  localparam logic [31:0] BRANCH = 32'h0000_0063;
  localparam logic [31:0] RETURN_WORD = 32'h0000_8067;
  // stimulus: redirect vector is mispredict, eret, trap, flush, debug
  logic        core_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        reduced_cfg = 1'b0;
  logic        clear_req = 1'b0;
  logic [4:0]  redir = 5'h00;
  addr_type    mis_pc = 32'h0;
  addr_type    epc = 32'h0;
  addr_type    trap_base = 32'h0;
  addr_type    flush_pc = 32'h0;
  addr_type    cf_pc = 32'h0000_7008;
  addr_type    err_pc = 32'h0000_6010;
  logic [31:0] cf_word = 32'h0000_0013;
  logic        btb_on = 1'b0;
  logic        bht_on = 1'b0;
  logic        ras_on = 1'b0;
  logic        decode_ready = 1'b0;
  // design outputs and memory model nets
  addr_type        lookup_pc;
  addr_type        mem_addr;
  logic            predictor_clear, btb_valid, bht_valid, mem_rd, cache_flush;
  logic            decode_valid;
  logic [31:0]     mem_data;
  logic            mem_err;
  fetch_entry_type decode_entry;
  int              num_errors = 0;
  int              n_compared = 0;
  always #10 core_clk_in = ~core_clk_in;
  // memory answers in the same cycle; filler words are plain 32-bit ops
  assign mem_data = (mem_addr == cf_pc) ? cf_word : {mem_addr[31:7], 7'h13};
  assign mem_err = mem_addr == err_pc;
  assign btb_valid = btb_on && (lookup_pc == cf_pc);
  assign bht_valid = bht_on && (lookup_pc == cf_pc);
  frontend_if frontend_if_inst ();
  fetch_frontend fetch_frontend_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .link(frontend_if_inst), .reduced_cfg_in(reduced_cfg), .boot_addr_in(BOOT),
    .mispredict_in(redir[0]), .mispredict_pc_in(mis_pc), .eret_in(redir[1]), .epc_in(epc),
    .trap_event_in(redir[2]), .trap_base_in(trap_base), .flush_in(redir[3]),
    .flush_redirect_select_in(redir[3]), .flush_resume_pc_in(flush_pc),
    .debug_redirect_event_in(redir[4]), .predictor_clear_request_in(clear_req),
    .lookup_pc_out(lookup_pc), .predictor_clear_out(predictor_clear),
    .btb_valid_in(btb_valid), .btb_target_in(32'h0000_7400), .bht_valid_in(bht_valid),
    .bht_taken_in(bht_on), .bht_target_in(32'h0000_7800), .ras_valid_in(ras_on),
    .ras_target_in(32'h0000_7C00));
  fetch_partner fetch_partner_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .link(frontend_if_inst), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
    .mem_data_in(mem_data), .mem_err_in(mem_err), .cache_flush_out(cache_flush),
    .decode_valid_out(decode_valid), .decode_entry_out(decode_entry),
    .decode_ready_in(decode_ready));
  fetch_link_monitor fetch_link_monitor_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .fetch_req(frontend_if_inst.fetch_req), .fetch_addr(frontend_if_inst.fetch_addr),
    .fetch_kill(frontend_if_inst.fetch_kill), .fetch_gnt(frontend_if_inst.fetch_gnt),
    .rsp_valid(frontend_if_inst.rsp_valid), .rsp_addr(frontend_if_inst.rsp_addr),
    .rsp_ex(frontend_if_inst.rsp_ex), .entry_valid(frontend_if_inst.entry_valid),
    .entry_ready(frontend_if_inst.entry_ready), .entry(frontend_if_inst.entry));
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  // redirects are given while decode keeps draining, so an old entry leaves before the next check
  task automatic pulse_redirect(input logic [4:0] m, input addr_type base);
    repeat (4) @(posedge core_clk_in);
    redir <= m;
    mis_pc <= base;
    epc <= base + 32'h0000_1000;
    trap_base <= base + 32'h0000_2000;
    flush_pc <= base + 32'h0000_3000;
    @(posedge core_clk_in);
    redir <= 5'h00;
  endtask
  // collects n entries; after index jump the stream continues at tgt
  task automatic check_seq(input addr_type start, input int n, input int jump,
                           input addr_type tgt, input logic stall);
    int       got;
    int       cyc;
    addr_type ea;
    got = 0;
    cyc = 0;
    while (got < n && cyc < 400)
    begin
      @(posedge core_clk_in);
      decode_ready <= !(stall && cyc > 2 && cyc < 30);
      #1;
      // an entry counts only in the cycle decode really takes it
      if (decode_valid === 1'b1 && decode_ready === 1'b1)
      begin
        ea = (got <= jump) ? start + addr_type'(4 * got) : tgt + addr_type'(4 * (got - jump - 1));
        cmp_word(decode_entry.addr, ea);
        cmp_word(decode_entry.instr, (ea == cf_pc) ? cf_word : {ea[31:7], 7'h13});
        cmp_bit(decode_entry.ex, ea == err_pc);
        cmp_bit(decode_entry.pred, got == jump && !ras_on);
        cmp_bit(decode_entry.ret, ea == cf_pc && cf_word == RETURN_WORD);
        got++;
      end
      cyc++;
    end
    cmp_bit(got == n, 1'b1);
    // decode keeps draining, so a later redirect leaves no stale entry in the holding stage
    @(posedge core_clk_in);
    decode_ready <= 1'b1;
  endtask
  task automatic test_boot();
    check_seq(BOOT, 4, 99, BOOT, 1'b0);
    @(posedge core_clk_in);
    clear_req <= 1'b1;
    @(posedge core_clk_in);
    clear_req <= 1'b0;
    #1 cmp_bit(predictor_clear, 1'b1);
    @(posedge core_clk_in);
    #1 cmp_bit(predictor_clear, 1'b0);
  endtask
  // every higher source joins the lower ones; the highest must win
  task automatic test_priority();
    for (int k = 0; k < 5; k++)
    begin
      pulse_redirect(5'((5'h02 << k) - 5'h01), 32'h0000_2000);
      check_seq((k == 4) ? `FE_DEBUG_ADDR : 32'h0000_2000 + addr_type'(32'h1000 * k), 3, 99,
                32'h0, 1'b0);
    end
  endtask
  task automatic test_flush();
    pulse_redirect(5'h08, 32'h0000_2100);
    #1;
    for (int i = 0; i < 10 && mem_rd !== 1'b1; i++)
      @(posedge core_clk_in) #1;
    cmp_bit(cache_flush, 1'b1);
    cmp_word(mem_addr, 32'h0000_5100);
    check_seq(32'h0000_5100, 2, 99, 32'h0, 1'b0);
  endtask
  // decode stalls long enough for the queue to fill and replay
  task automatic test_stall();
    pulse_redirect(5'h01, 32'h0000_6000);
    check_seq(32'h0000_6000, 12, 99, 32'h0, 1'b1);
  endtask
  task automatic predict_case(input logic [31:0] w, input logic b, input logic h,
                              input int jump, input addr_type tgt);
    @(posedge core_clk_in);
    cf_word <= w;
    btb_on <= b;
    bht_on <= h;
    pulse_redirect(5'h01, 32'h0000_7000);
    check_seq(32'h0000_7000, 5, jump, tgt, 1'b0);
  endtask
  task automatic test_predict();
    predict_case(JALR, 1'b1, 1'b0, 2, 32'h0000_7400);
    predict_case(JALR, 1'b0, 1'b0, 99, 32'h0);
    predict_case(BRANCH, 1'b0, 1'b1, 2, 32'h0000_7800);
    predict_case(BRANCH, 1'b0, 1'b0, 99, 32'h0);
    ras_on <= 1'b1;
    predict_case(RETURN_WORD, 1'b0, 1'b0, 2, 32'h0000_7C00);
    ras_on <= 1'b0;
    @(posedge core_clk_in);
    reduced_cfg <= 1'b1;
    predict_case(JALR, 1'b1, 1'b1, 99, 32'h0);
    pulse_redirect(5'h11, 32'h0000_2200);
    check_seq(32'h0000_2200, 2, 99, 32'h0, 1'b0);
    @(posedge core_clk_in);
    reduced_cfg <= 1'b0;
  endtask
  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    test_boot();
    test_priority();
    test_flush();
    test_stall();
    test_predict();
    summarize();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (30000) @(posedge core_clk_in);
    num_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    summarize();
  end
endmodule
